// file: design/sft_defines.svh
`ifndef SFT_DEFINES_SVH
`define SFT_DEFINES_SVH

////////////////////////////////////////////////////////////////
// Register byte offsets on the bus
`define SFT_OFF_DATA 8'h00
`define SFT_OFF_STATUS 8'h04
`define SFT_OFF_CTRLB 8'h08
`define SFT_OFF_CTRLC 8'h0c
`define SFT_OFF_BAUD 8'h10

////////////////////////////////////////////////////////////////
// Status word bit positions
`define SFT_ST_BUF_EMPTY 0
`define SFT_ST_TX_DONE 1
`define SFT_ST_FRAME_ERR 2
`define SFT_ST_BUSY 3

// Line control b bit positions
`define SFT_CB_TX_EN 0
`define SFT_CB_NINTH 1
`define SFT_CB_SIZE2 2
`define SFT_CB_DBL 3
`define SFT_CB_RX_EN 4

// Line control c bit positions
`define SFT_CC_SIZE_LO 0
`define SFT_CC_PAR_LO 2
`define SFT_CC_STOP2 4
`define SFT_CC_SYNC 5

////////////////////////////////////////////////////////////////
// Reset values: eight data bits, no parity, one stop bit
`define SFT_RST_CTRLB 5'h00
`define SFT_RST_CTRLC 6'h03
`define SFT_RST_BAUD 12'h000

////////////////////////////////////////////////////////////////
// Baud ticks per bit: normal, double speed, synchronous
`define SFT_DIV_NORMAL 5'h10
`define SFT_DIV_DOUBLE 5'h08
`define SFT_DIV_SYNC 5'h02

`endif

// file: design/sft_pkg.sv
package sft_pkg;

	// Transmit shifter states
	typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP1, TX_STOP2} sft_tx_state_t;

	// One character, up to nine bits
	typedef logic [8:0] sft_char_t;

	// Data bits per frame from the size code; codes 4..6 fall back to eight
	function automatic logic [3:0] sft_char_bits(input logic [2:0] code);
		logic [3:0] n;
		n = 4'h8;
		if (code == 3'h7) begin
			n = 4'h9;
		end else if (code < 3'h4) begin
			n = 4'h5 + {2'h0, code[1:0]};
		end
		return n;
	endfunction

	// Clears the bits above the character size
	function automatic sft_char_t sft_mask(input sft_char_t d, input logic [2:0] code);
		logic [3:0] n;
		n = sft_char_bits(code);
		return d & (9'h1ff >> (4'h9 - n));
	endfunction

	// Even parity is the xor of the data, odd its inverse
	function automatic logic sft_parity(input sft_char_t d, input logic odd);
		return (^d) ^ odd;
	endfunction

endpackage

// file: design/sft_baud_gen.sv
`include "sft_defines.svh"

module sft_baud_gen (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Settings
	input wire logic [11:0] divisor,
	input wire logic reload,
	input wire logic double_speed,
	input wire logic sync_mode,
	// Ticks
	output logic baud_tick,
	output logic bit_tick,
	output logic xck_level
);
	import sft_pkg::*;

	logic [11:0] cnt_ff; // Down counter
	logic [3:0] pre_ff; // Ticks within one bit
	wire logic [4:0] div = sync_mode ? `SFT_DIV_SYNC :
		(double_speed ? `SFT_DIV_DOUBLE : `SFT_DIV_NORMAL);
	wire logic pre_last = ({1'b0, pre_ff} == div - 5'h01);
	wire logic [11:0] nxt_cnt = (reload | baud_tick) ? divisor : cnt_ff - 12'h001;
	wire logic [3:0] nxt_pre = !baud_tick ? pre_ff : (pre_last ? 4'h0 : pre_ff + 4'h1);

	assign baud_tick = (cnt_ff == 12'h000);
	assign bit_tick = baud_tick & pre_last;
	// Falls on the edge at which the bit changes; its registered copy rises there only when the divisor is zero
	assign xck_level = pre_ff[0];

	////////////////////////////////////////////////////////////////
	// Prescaler and bit divider run free so bit edges stay regular
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_ff <= 12'h000;
			pre_ff <= 4'h0;
		end else begin
			cnt_ff <= nxt_cnt;
			pre_ff <= nxt_pre;
		end
	end
endmodule

// file: design/sft_rx_stop_check.sv
`include "sft_defines.svh"

module sft_rx_stop_check (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Line and settings
	input wire logic rxd_in,
	input wire logic enable,
	input wire logic baud_tick,
	input wire logic double_speed,
	input wire logic [2:0] char_size_code,
	input wire logic parity_on,
	// Frame result
	output logic frame_done,
	output logic frame_err
);
	import sft_pkg::*;

	logic rx_meta_ff; // First synchroniser stage
	logic rx_sync_ff; // Second stage, the only one read
	logic busy_ff;
	logic [3:0] phase_ff;
	logic [3:0] bitn_ff;
	// Five bits wide so that sixteen ticks per bit do not fold to zero
	wire logic [4:0] div = double_speed ? `SFT_DIV_DOUBLE : `SFT_DIV_NORMAL;
	wire logic mid = baud_tick & busy_ff & ({1'b0, phase_ff} == (div >> 1));
	// Index of the first stop bit; a second one is never looked at
	wire logic [3:0] stop_idx = sft_char_bits(char_size_code) + {3'h0, parity_on} + 4'h1;
	wire logic false_start = mid & (bitn_ff == 4'h0) & rx_sync_ff;
	wire logic at_stop = mid & (bitn_ff == stop_idx);

	assign frame_done = at_stop;
	assign frame_err = at_stop & ~rx_sync_ff;

	////////////////////////////////////////////////////////////////
	// Start detect, mid-bit sampling, stop after the first stop bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_meta_ff <= 1'b1;
			rx_sync_ff <= 1'b1;
			busy_ff <= 1'b0;
			phase_ff <= 4'h0;
			bitn_ff <= 4'h0;
		end else begin
			rx_meta_ff <= rxd_in;
			rx_sync_ff <= rx_meta_ff;
			if (!busy_ff) begin
				busy_ff <= enable & ~rx_sync_ff;
				phase_ff <= 4'h0;
				bitn_ff <= 4'h0;
			end else if (!enable || false_start || at_stop) begin
				busy_ff <= 1'b0;
			end else if (baud_tick) begin
				phase_ff <= ({1'b0, phase_ff} == div - 5'h01) ? 4'h0 : phase_ff + 4'h1;
				bitn_ff <= mid ? bitn_ff + 4'h1 : bitn_ff;
			end
		end
	end
endmodule

// file: design/sft_top.sv
// Our own choices: the register offsets and register access over AHB-Lite.
`include "sft_defines.svh"

module sft_top (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Normal port function of the serial output pin
	input wire logic port_txd_out,
	input wire logic port_txd_oe_n,
	// Serial output pin
	output logic txd_out,
	output logic txd_oe_n,
	// Serial input pin, asynchronous
	input wire logic rxd_in,
	// Transfer clock pin
	output logic transfer_clock_pin_out,
	output logic transfer_clock_pin_oe_n
);
	import sft_pkg::*;

	////////////////////////////////////////////////////////////////
	// Bus capture
	logic wr_pend_ff; // Write waiting for its data phase
	logic [7:0] wr_addr_ff; // Its byte offset
	logic [31:0] hrdata_ff; // Read data for the data phase

	// Software registers
	logic [4:0] ctrlb_ff; // line_control_b
	logic [5:0] ctrlc_ff; // line_control_c
	logic [11:0] baud_ff; // Baud divisor
	logic frame_error_flag_ff; // Result of last received frame

	// Transmit buffer
	sft_char_t buf_ff;
	logic buf_full_ff;

	// Shifter
	sft_tx_state_t state_ff;
	sft_char_t shift_ff;
	logic [3:0] bitcnt_ff;
	logic par_ff;
	logic txd_ff;
	logic tx_active_ff; // Transmitter owns the pin
	logic tx_complete_flag_ff;
	logic xck_ff;

	// Ticks from the baud generator, frame result from the receiver check
	logic baud_tick;
	logic bit_tick;
	logic xck_level;
	logic rx_frame_done;
	logic rx_frame_err;

	////////////////////////////////////////////////////////////////
	// Address decode and write strobes
	wire logic addr_valid = hsel & htrans[1] & hready;
	wire logic wr_data = wr_pend_ff & (wr_addr_ff == `SFT_OFF_DATA);
	wire logic wr_status = wr_pend_ff & (wr_addr_ff == `SFT_OFF_STATUS);
	wire logic wr_ctrlb = wr_pend_ff & (wr_addr_ff == `SFT_OFF_CTRLB);
	wire logic wr_ctrlc = wr_pend_ff & (wr_addr_ff == `SFT_OFF_CTRLC);
	wire logic wr_baud = wr_pend_ff & (wr_addr_ff == `SFT_OFF_BAUD);

	// Named control fields, one set shared by both directions
	wire logic tx_enable_bit = ctrlb_ff[`SFT_CB_TX_EN];
	wire logic tx_ninth_bit = ctrlb_ff[`SFT_CB_NINTH];
	wire logic double_speed_bit = ctrlb_ff[`SFT_CB_DBL];
	wire logic rx_enable_bit = ctrlb_ff[`SFT_CB_RX_EN];
	wire logic [2:0] char_size_code = {ctrlb_ff[`SFT_CB_SIZE2],
		ctrlc_ff[`SFT_CC_SIZE_LO+1:`SFT_CC_SIZE_LO]};
	wire logic [1:0] parity_mode_field = ctrlc_ff[`SFT_CC_PAR_LO+1:`SFT_CC_PAR_LO];
	wire logic parity_on = parity_mode_field[1];
	wire logic parity_odd = parity_mode_field[0];
	wire logic stop_bits_select = ctrlc_ff[`SFT_CC_STOP2];
	wire logic sync_mode = ctrlc_ff[`SFT_CC_SYNC];

	// Status view
	wire logic tx_buffer_empty_flag = ~buf_full_ff;
	wire logic tx_busy = (state_ff != TX_IDLE);
	wire logic [31:0] status_word = {28'h000_0000, tx_busy, frame_error_flag_ff,
		tx_complete_flag_ff, tx_buffer_empty_flag};

	// Read selection; unmapped offsets read as zero
	wire logic [7:0] rd_addr = haddr[7:0];
	wire logic [31:0] rd_word =
		(rd_addr == `SFT_OFF_DATA) ? {23'h00_0000, buf_ff} :
		(rd_addr == `SFT_OFF_STATUS) ? status_word :
		(rd_addr == `SFT_OFF_CTRLB) ? {27'h000_0000, ctrlb_ff} :
		(rd_addr == `SFT_OFF_CTRLC) ? {26'h000_0000, ctrlc_ff} :
		(rd_addr == `SFT_OFF_BAUD) ? {20'h0_0000, baud_ff} : 32'h0000_0000;

	// Never waits, never errors
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_ff;

	////////////////////////////////////////////////////////////////
	// Bus pipeline: address phase captured, write applied next cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			hrdata_ff <= 32'h0000_0000;
		end else begin
			wr_pend_ff <= addr_valid & hwrite;
			wr_addr_ff <= addr_valid ? haddr[7:0] : wr_addr_ff;
			// Read data latched at the address phase edge
			if (addr_valid && !hwrite) begin
				hrdata_ff <= rd_word;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Control registers; format is only safe to change while idle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrlb_ff <= `SFT_RST_CTRLB;
			ctrlc_ff <= `SFT_RST_CTRLC;
			baud_ff <= `SFT_RST_BAUD;
		end else begin
			if (wr_ctrlb) begin
				ctrlb_ff <= hwdata[4:0];
			end
			if (wr_ctrlc) begin
				ctrlc_ff <= hwdata[5:0];
			end
			if (wr_baud) begin
				baud_ff <= hwdata[11:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Baud generator and bit divider
	sft_baud_gen u_baud (
		.hclk(hclk),
		.hresetn(hresetn),
		.divisor(baud_ff),
		.reload(wr_baud),
		.double_speed(double_speed_bit),
		.sync_mode(sync_mode),
		.baud_tick(baud_tick),
		.bit_tick(bit_tick),
		.xck_level(xck_level)
	);

	////////////////////////////////////////////////////////////////
	// Receiver stop-bit check on the same format
	sft_rx_stop_check u_rxchk (
		.hclk(hclk),
		.hresetn(hresetn),
		.rxd_in(rxd_in),
		.enable(rx_enable_bit),
		.baud_tick(baud_tick),
		.double_speed(double_speed_bit),
		.char_size_code(char_size_code),
		.parity_on(parity_on),
		.frame_done(rx_frame_done),
		.frame_err(rx_frame_err)
	);

	////////////////////////////////////////////////////////////////
	// Shifter sequencing
	wire logic [3:0] nbits = sft_char_bits(char_size_code);
	wire logic last_data = (bitcnt_ff == nbits - 4'h1);
	wire logic can_load = buf_full_ff & tx_active_ff;
	// Final stop bit ends on this tick
	wire logic frame_end = bit_tick & (((state_ff == TX_STOP1) & ~stop_bits_select) |
		(state_ff == TX_STOP2));
	wire logic idle_load = bit_tick & (state_ff == TX_IDLE) & can_load;
	wire logic load = idle_load | (frame_end & can_load);
	wire logic buf_write = wr_data;

	// Next state, taken only on bit ticks
	sft_tx_state_t nxt_state;
	always_comb begin
		nxt_state = state_ff;
		if (bit_tick) begin
			unique case (state_ff)
				TX_IDLE: nxt_state = can_load ? TX_START : TX_IDLE;
				TX_START: nxt_state = TX_DATA;
				TX_DATA: nxt_state = !last_data ? TX_DATA :
					(parity_on ? TX_PARITY : TX_STOP1);
				TX_PARITY: nxt_state = TX_STOP1;
				TX_STOP1: nxt_state = stop_bits_select ? TX_STOP2 :
					(can_load ? TX_START : TX_IDLE);
				TX_STOP2: nxt_state = can_load ? TX_START : TX_IDLE;
			endcase
		end
	end

	// Data bits leave from bit zero upward
	wire sft_char_t nxt_shift = load ? buf_ff :
		((bit_tick && state_ff == TX_DATA) ? (shift_ff >> 1) : shift_ff);
	wire logic [3:0] nxt_bitcnt = load ? 4'h0 :
		((bit_tick && state_ff == TX_DATA) ? bitcnt_ff + 4'h1 : bitcnt_ff);
	// Parity fixed at load from the masked character
	wire logic nxt_par = load ? sft_parity(buf_ff, parity_odd) : par_ff;
	// Line level follows the state being entered
	wire logic nxt_txd = (nxt_state == TX_START) ? 1'b0 :
		(nxt_state == TX_DATA) ? nxt_shift[0] :
		(nxt_state == TX_PARITY) ? nxt_par : 1'b1;

	// Transmitter stays on until shifter and buffer drain
	wire logic nxt_tx_active = tx_enable_bit |
		(tx_active_ff & ((nxt_state != TX_IDLE) | buf_full_ff));

	////////////////////////////////////////////////////////////////
	// Shifter registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= TX_IDLE;
			shift_ff <= 9'h000;
			bitcnt_ff <= 4'h0;
			par_ff <= 1'b0;
			txd_ff <= 1'b1;
			tx_active_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			shift_ff <= nxt_shift;
			bitcnt_ff <= nxt_bitcnt;
			par_ff <= nxt_par;
			txd_ff <= nxt_txd;
			tx_active_ff <= nxt_tx_active;
		end
	end

	////////////////////////////////////////////////////////////////
	// Transmit buffer; a write in the load cycle still fills it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			buf_ff <= 9'h000;
			buf_full_ff <= 1'b0;
		end else begin
			if (buf_write) begin
				// Ninth bit is taken from control at this write
				buf_ff <= sft_mask({tx_ninth_bit, hwdata[7:0]}, char_size_code);
				buf_full_ff <= 1'b1;
			end else if (load) begin
				buf_full_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Completion flag: set wins over a one written to clear it
	wire logic tx_done_set = frame_end & ~buf_full_ff;
	wire logic tx_done_clr = wr_status & hwdata[`SFT_ST_TX_DONE];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_complete_flag_ff <= 1'b0;
			frame_error_flag_ff <= 1'b0;
		end else begin
			if (tx_done_set) begin
				tx_complete_flag_ff <= 1'b1;
			end else if (tx_done_clr) begin
				tx_complete_flag_ff <= 1'b0;
			end
			// Follows each received frame
			if (rx_frame_done) begin
				frame_error_flag_ff <= rx_frame_err;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Pins: transmitter overrides the port while active
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			xck_ff <= 1'b0;
		end else begin
			xck_ff <= xck_level;
		end
	end

	assign txd_out = tx_active_ff ? txd_ff : port_txd_out;
	assign txd_oe_n = tx_active_ff ? 1'b0 : port_txd_oe_n;
	// Master clock out only in synchronous mode
	assign transfer_clock_pin_out = xck_ff;
	assign transfer_clock_pin_oe_n = ~(sync_mode & tx_active_ff);

endmodule

// file: verification/sft_top_props.sv
////////////////////////////////////////////////////////////////
// Port checker for the frame transmitter
module sft_top_props (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus answer
	input wire logic hreadyout,
	input wire logic hresp,
	// Serial and clock pins
	input wire logic port_txd_out,
	input wire logic txd_out,
	input wire logic txd_oe_n,
	input wire logic transfer_clock_pin_out,
	input wire logic transfer_clock_pin_oe_n
);
	// One domain, so one clocking and one disable
	default clocking cb_clk @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_bus_no_wait: assert property (hreadyout)
		else $error("bus slave inserted a wait state");
	a_bus_resp_okay: assert property (!hresp)
		else $error("bus slave gave an error response");
	a_pin_port_follow: assert property (txd_oe_n |-> (txd_out == port_txd_out))
		else $error("released pin does not follow the port level");
	a_clk_needs_tx: assert property (!transfer_clock_pin_oe_n |-> !txd_oe_n)
		else $error("clock pin driven while transmitter is off");
	a_clk_edge_data: assert property ((!transfer_clock_pin_oe_n && $past(!transfer_clock_pin_oe_n)
		&& $changed(txd_out)) |-> $rose(transfer_clock_pin_out))
		else $error("serial data changed without a rising clock pin edge");
	a_take_idle_high: assert property ($fell(txd_oe_n) |-> txd_out)
		else $error("transmitter took the pin at a low level");
	a_release_after_stop: assert property ($rose(txd_oe_n) |-> ($past(txd_out, 1)
		&& $past(txd_out, 2)))
		else $error("pin released before the last stop bit ended");
	a_start_whole_bit: assert property ((!txd_oe_n && $fell(txd_out)) |=> !txd_out)
		else $error("start bit shorter than the shortest bit time");

	// Main scenarios reached
	c_take_pin: cover property ($fell(txd_oe_n));
	c_sync_clock: cover property (!transfer_clock_pin_oe_n && $rose(transfer_clock_pin_out));
	c_drop_pin: cover property ($rose(txd_oe_n));
endmodule

bind sft_top sft_top_props chk_u (
	.hclk(hclk),
	.hresetn(hresetn),
	.hreadyout(hreadyout),
	.hresp(hresp),
	.port_txd_out(port_txd_out),
	.txd_out(txd_out),
	.txd_oe_n(txd_oe_n),
	.transfer_clock_pin_out(transfer_clock_pin_out),
	.transfer_clock_pin_oe_n(transfer_clock_pin_oe_n)
);

// file: verification/sft_remote_xcvr.sv
////////////////////////////////////////////////////////////////
// Far-end transceiver: samples frames mid bit, sends test frames
module sft_remote_xcvr (
	// Clock and line
	input wire logic hclk,
	input wire logic txd_out,
	input wire logic txd_oe_n,
	output logic rxd_in,
	// Expected format
	input wire logic [7:0] bit_clks,
	input wire logic [3:0] nbits,
	input wire logic par_on,
	input wire logic stop2,
	// Last frame seen
	output logic [8:0] got_data,
	output logic got_par,
	output logic [1:0] got_stop,
	output logic [15:0] got_cnt,
	output logic [31:0] got_start
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] cyc; // Free cycle count for start times
	logic [8:0] d;

	always @(posedge hclk) cyc <= cyc + 32'h0000_0001;

	// Receive loop; a start is only taken while the pin is driven
	initial begin
		cyc = 32'h0000_0000;
		rxd_in = 1'b1;
		got_cnt = 16'h0000;
		forever begin
			@(posedge hclk);
			if (txd_oe_n === 1'b0 && txd_out === 1'b0) begin
				got_start = cyc;
				d = 9'h000;
				repeat (bit_clks / 8'h02 - 8'h01) @(posedge hclk);
				// LSB first after the start bit
				for (int i = 0; i < nbits; i++) begin
					repeat (bit_clks) @(posedge hclk);
					d[i] = txd_out;
				end
				got_data = d;
				if (par_on) begin
					repeat (bit_clks) @(posedge hclk);
					got_par = txd_out;
				end
				repeat (bit_clks) @(posedge hclk);
				got_stop = {1'b1, txd_out};
				if (stop2) begin
					repeat (bit_clks) @(posedge hclk);
					got_stop[1] = txd_out;
				end
				got_cnt = got_cnt + 16'h0001;
			end
		end
	end

	// Sends start, eight data bits and two chosen stop levels
	task automatic send(input logic [7:0] v, input logic s1, input logic s2);
		logic [10:0] f;
		f = {s2, s1, v, 1'b0};
		for (int i = 0; i < 11; i++) begin
			rxd_in <= f[i];
			repeat (bit_clks) @(posedge hclk);
		end
		rxd_in <= 1'b1; // Idle line sits high
	endtask
endmodule

// file: verification/sft_tb_top.sv
`include "sft_defines.svh"

`define SFT_TB_CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
	$display("mismatch at %0t got %h expected %h", $time, (a), (e)); end end

module sft_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk, hresetn, hsel, hwrite, par_on, stop2, got_par, port_txd_out;
	logic hreadyout, hresp, txd_out, txd_oe_n, rxd_in, xck_out, xck_oe_n;
	logic [1:0] htrans, got_stop;
	logic [2:0] hsize, code;
	logic [3:0] nbits;
	logic [7:0] bit_clks;
	logic [8:0] got_data, d, exp_d;
	logic [15:0] got_cnt, cnt0;
	logic [31:0] haddr, hwdata, hrdata, rd, cb, got_start, t0;
	int miscompares, comparisons;

	// 10 MHz bus clock
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end

	sft_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.port_txd_out(port_txd_out), .port_txd_oe_n(1'b1), .txd_out(txd_out),
		.txd_oe_n(txd_oe_n), .rxd_in(rxd_in), .transfer_clock_pin_out(xck_out),
		.transfer_clock_pin_oe_n(xck_oe_n));

	sft_remote_xcvr peer_u (.hclk(hclk), .txd_out(txd_out), .txd_oe_n(txd_oe_n),
		.rxd_in(rxd_in), .bit_clks(bit_clks), .nbits(nbits), .par_on(par_on),
		.stop2(stop2), .got_data(got_data), .got_par(got_par), .got_stop(got_stop),
		.got_cnt(got_cnt), .got_start(got_start));

	////////////////////////////////////////////////////////////////
	// One single transfer; an idle cycle follows so reads see fresh values
	task automatic ahb_xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= v;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
		hsel <= 1'b0;
		@(posedge hclk);
	endtask

	// Baud, then format, then enable
	task automatic set_fmt(input logic [2:0] c, input logic [1:0] pm, input logic s2,
		input logic dbl, input logic sy, input logic rx);
		ahb_xfer(1'b1, `SFT_OFF_BAUD, 32'h0000_0000);
		ahb_xfer(1'b1, `SFT_OFF_CTRLC, {26'h0, sy, s2, pm, c[1:0]});
		cb = {27'h0, rx, dbl, c[2], 1'b0, 1'b1};
		ahb_xfer(1'b1, `SFT_OFF_CTRLB, cb);
		nbits <= (c == 3'h7) ? 4'h9 : 4'h5 + {2'h0, c[1:0]};
		par_on <= pm[1];
		stop2 <= s2;
	endtask

	// Polling send: wait for room, clear complete, ninth bit, low byte
	task automatic send_char(input logic [8:0] v);
		rd = 32'h0000_0000;
		while (rd[`SFT_ST_BUF_EMPTY] !== 1'b1) ahb_xfer(1'b0, `SFT_OFF_STATUS, 32'h0);
		ahb_xfer(1'b1, `SFT_OFF_STATUS, 32'h0000_0001 << `SFT_ST_TX_DONE);
		ahb_xfer(1'b1, `SFT_OFF_CTRLB, cb | {30'h0, v[8], 1'b0});
		ahb_xfer(1'b1, `SFT_OFF_DATA, {24'h00_0000, v[7:0]});
	endtask

	// Bounded wait for frames counted from cnt0
	task automatic wait_frames(input logic [15:0] n);
		for (int k = 0; k < 20000 && got_cnt !== cnt0 + n; k++) @(posedge hclk);
	endtask

	task automatic stop_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Watchdog, well beyond the expected run length
	initial begin
		#6000000;
		miscompares++;
		stop_test();
	end

	////////////////////////////////////////////////////////////////
	initial begin
		hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
		hsize = 3'h2; hwdata = 32'h0; port_txd_out = 1'b1; bit_clks = 8'h10;
		nbits = 4'h8; par_on = 1'b0; stop2 = 1'b0; cb = 32'h0; cnt0 = 16'h0;
		miscompares = 0; comparisons = 0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// Reset state, unmapped place, pin left to the port
		ahb_xfer(1'b0, `SFT_OFF_CTRLC, 32'h0); `SFT_TB_CHK(rd, 32'h0000_0003)
		ahb_xfer(1'b0, `SFT_OFF_STATUS, 32'h0); `SFT_TB_CHK(rd, 32'h0000_0001)
		ahb_xfer(1'b0, 8'h14, 32'h0); `SFT_TB_CHK(rd, 32'h0000_0000)
		port_txd_out <= 1'b0;
		repeat (2) @(posedge hclk);
		`SFT_TB_CHK(txd_out, 1'b0)
		port_txd_out <= 1'b1;
		// Every size, parity and stop combination
		for (int i = 0; i < 30; i++) begin
			code = (i % 5 == 4) ? 3'h7 : 3'(i % 5);
			set_fmt(code, (i / 5 % 3 == 0) ? 2'h0 : 2'(i / 5 % 3 + 1), 1'(i / 15), 1'b0, 1'b0, 1'b0);
			d = 9'h1a5 ^ 9'(i * 37);
			exp_d = d & ~(9'h1ff << ((code == 3'h7) ? 9 : 5 + code));
			cnt0 = got_cnt;
			send_char(d);
			wait_frames(16'h0001);
			`SFT_TB_CHK(got_data, exp_d)
			if (par_on) `SFT_TB_CHK(got_par, ^exp_d ^ (i / 5 % 3 == 2))
			`SFT_TB_CHK(got_stop, 2'h3)
			repeat (32) @(posedge hclk);
			ahb_xfer(1'b0, `SFT_OFF_STATUS, 32'h0); `SFT_TB_CHK(rd[1:0], 2'h3)
		end
		// Back to back, then disable while still pending; normal and double speed
		for (int s = 0; s < 2; s++) begin
			set_fmt(3'h3, 2'h0, 1'b0, 1'(s), 1'b0, 1'b0);
			bit_clks <= s ? 8'h08 : 8'h10;
			cnt0 = got_cnt;
			send_char(9'h03c);
			send_char(9'h0c3);
			ahb_xfer(1'b0, `SFT_OFF_STATUS, 32'h0); `SFT_TB_CHK(rd[0], 1'b0)
			ahb_xfer(1'b1, `SFT_OFF_CTRLB, cb & 32'hffff_fffe);
			`SFT_TB_CHK(txd_oe_n, 1'b0)
			wait_frames(16'h0001);
			t0 = got_start;
			`SFT_TB_CHK(got_data, 9'h03c)
			wait_frames(16'h0002);
			`SFT_TB_CHK(got_start - t0, 32'(bit_clks) * 10)
			`SFT_TB_CHK(got_data, 9'h0c3)
			repeat (48) @(posedge hclk);
			`SFT_TB_CHK(txd_oe_n, 1'b1)
		end
		// Synchronous master: two clocks per bit
		set_fmt(3'h3, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0);
		bit_clks <= 8'h02;
		cnt0 = got_cnt;
		send_char(9'h05a);
		`SFT_TB_CHK(xck_oe_n, 1'b0)
		wait_frames(16'h0001);
		`SFT_TB_CHK(got_data, 9'h05a)
		// Receiver shares the format; only the first stop bit counts
		set_fmt(3'h3, 2'h0, 1'b1, 1'b0, 1'b0, 1'b1);
		bit_clks <= 8'h10;
		@(posedge hclk);
		peer_u.send(8'h96, 1'b0, 1'b1);
		ahb_xfer(1'b0, `SFT_OFF_STATUS, 32'h0); `SFT_TB_CHK(rd[2], 1'b1)
		// Let a frame started by the low stop level run out first
		repeat (200) @(posedge hclk);
		peer_u.send(8'h69, 1'b1, 1'b0);
		ahb_xfer(1'b0, `SFT_OFF_STATUS, 32'h0); `SFT_TB_CHK(rd[2], 1'b0)
		stop_test();
	end
endmodule
